// [rtl/eeprom_i2c_pkg.sv]
// Purpose: shared constants and types for the serial eeprom master
// Assumes: 40 MHz system clock, byte-wide special function register port
// Notes:   serial clock quarter period derived from the clock and bus rates

package eeprom_i2c_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] SERIAL_BYTE_ADDR = 8'h9e;
  localparam logic [7:0] SERIAL_CMD_ADDR  = 8'h9f;

  // status bit positions in serial_command_status
  localparam int STAT_ERROR_BIT = 7;
  localparam int STAT_BUSY_BIT  = 6;
  localparam int STAT_RXACK_BIT = 5;
  localparam int STAT_TXACK_BIT = 4;
  localparam int CMD_MSB        = 3;

  // command codes
  localparam logic [3:0] CMD_NOOP     = 4'h0;
  localparam logic [3:0] CMD_TRANSMIT = 4'h3;
  localparam logic [3:0] CMD_STOP     = 4'h5;
  localparam logic [3:0] CMD_RECEIVE  = 4'h6;
  localparam logic [3:0] CMD_START    = 4'h9;

  // reset values
  localparam logic       ACK_N_RESET  = 1'b1;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] RDATA_RESET  = 8'h00;
  localparam logic [3:0] STAT_LOW_PAD = 4'h0;

  // timing: serial clock is four quarter phases per bit
  localparam int CLK_FREQ_HZ    = 40_000_000;
  localparam int SCL_FREQ_HZ    = 78_000;
  localparam int QUARTERS       = 4;
  localparam int QUARTER_CYCLES = CLK_FREQ_HZ / (SCL_FREQ_HZ * QUARTERS);

  // byte framing: eight data bits then one acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // quarter phase codes
  localparam logic [1:0] Q_CLK_LOW  = 2'h0;
  localparam logic [1:0] Q_DATA_A   = 2'h1;
  localparam logic [1:0] Q_CLK_HIGH = 2'h2;
  localparam logic [1:0] Q_DATA_B   = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_STOP,
    ST_XFER
  } seq_state_e;

  typedef struct packed {
    logic error;
    logic busy;
    logic rx_ack_n;
    logic tx_ack_n;
  } status_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage : eeprom_i2c_pkg

// [rtl/scl_tick_gen.sv]
// Purpose: one-cycle enable pulse every DIV clocks while running
// Assumes: single clock domain, synchronous restart
// Notes:   counter held at zero while stopped so the first quarter is full

`timescale 1ns/10ps

module scl_tick_gen #(
  parameter int DIV = 128
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_run,
  input  wire logic i_restart,
  output logic      o_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_ff;
  logic          tick_ff;
  wire           wrap = (count_ff == LAST);

  // divider, restarted on each accepted bus command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else if (!i_run || i_restart) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= wrap ? '0 : count_ff + 1'b1;
      tick_ff  <= wrap;
    end
  end

  assign o_tick = tick_ff;

endmodule : scl_tick_gen

// [rtl/eeprom_i2c_master.sv]
// Purpose: byte-oriented serial eeprom master behind two sfr registers
// Assumes: processor waits for busy to fall before the next command
// Notes:   pins are open drain; gpio logic owns them unless selected
//
// How it works
// RL1 - processor loads data byte first, then writes transmit command to start.
// RL2 - transmit command shifts data byte out, then samples eeprom acknowledge.
// RL3 - status bit 6 is busy: one during a bus operation, reset zero.
// RL4 - interrupt output pulses when busy falls from one to zero.
// RL5 - status bit 5 resets one, reads zero when eeprom acknowledged last byte.
// RL6 - status bit 4 resets one, reads zero once block drove acknowledge.
// RL7 - receive command shifts a byte in and presents it in data register.
// RL8 - serial clock near 78 kHz during transfers, held high when stopped.
// RL9 - no-op command stops serial clock; otherwise clock keeps toggling.
// RL10 - command 5 generates a stop condition on the bus.
// RL11 - command 9 generates a start condition on the bus.
// RL12 - undefined command does nothing on the bus and sets error bit 7.
// RL13 - command field is bits 3 to 0, write-only, resets to zero.
// RL14 - sole master: no clock stretching, no arbitration.
// RL15 - serial pins reach shared gpio pins only while pin select is set.
// RL16 - firmware should not bit-bang the eeprom through the shared pins.
// RL17 - bytes go most significant bit first; data changes only with clock low.
// RL18 - processor must not write a new command while busy.

`timescale 1ns/10ps

module eeprom_i2c_master
  import eeprom_i2c_pkg::*;
#(
  parameter int QUARTER_DIV = eeprom_i2c_pkg::QUARTER_CYCLES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic [7:0]                i_sfr_addr,
  input  wire logic                      i_sfr_wr,
  input  wire logic [7:0]                i_sfr_wdata,
  output logic      [7:0]                o_sfr_rdata,
  input  wire logic                      i_eeprom_pin_select,
  input  wire eeprom_i2c_pkg::pin_drive_s i_gpio_clock,
  input  wire eeprom_i2c_pkg::pin_drive_s i_gpio_data,
  output logic                           o_gpio_clock_in,
  output logic                           o_gpio_data_in,
  input  wire logic                      i_shared_pin_clock_in,
  output logic                           o_shared_pin_clock_out,
  output logic                           o_shared_pin_clock_oe,
  input  wire logic                      i_shared_pin_data_in,
  output logic                           o_shared_pin_data_out,
  output logic                           o_shared_pin_data_oe,
  output logic                           o_eeprom_done_irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  seq_state_e  state_ff;
  seq_state_e  nxt_state;
  status_s     status_ff;
  logic [7:0]  serial_byte_ff;
  logic [7:0]  shift_ff;
  logic [3:0]  bit_idx_ff;
  logic [1:0]  quarter_ff;
  logic        receive_ff;
  logic        clk_run_ff;
  logic        scl_ff;
  logic        sda_ff;
  logic        irq_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  sda_sync_ff;
  logic [1:0]  scl_sync_ff;
  pin_drive_s  clk_pin_ff;
  pin_drive_s  data_pin_ff;
  logic        tick;

  // ------------------------------------------------------------------
  // pin input synchronisers: first stage feeds only the second
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_sync_ff <= 2'b11;
      scl_sync_ff <= 2'b11;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], i_shared_pin_data_in};
      scl_sync_ff <= {scl_sync_ff[0], i_shared_pin_clock_in};
    end
  end

  wire sda_in = sda_sync_ff[1];

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  wire        idle       = (state_ff == ST_IDLE);
  wire        cmd_wr     = i_sfr_wr && (i_sfr_addr == SERIAL_CMD_ADDR);
  wire        byte_wr    = i_sfr_wr && (i_sfr_addr == SERIAL_BYTE_ADDR);
  wire [3:0]  cmd_code   = i_sfr_wdata[CMD_MSB:0];
  // commands written while busy are dropped; nothing else can abort a byte
  wire        cmd_take   = cmd_wr && idle;
  wire        is_noop    = (cmd_code == CMD_NOOP);
  wire        is_tx      = (cmd_code == CMD_TRANSMIT);
  wire        is_rx      = (cmd_code == CMD_RECEIVE);
  wire        is_stop    = (cmd_code == CMD_STOP);
  wire        is_start   = (cmd_code == CMD_START);
  wire        is_bus_op  = is_tx || is_rx || is_stop || is_start;
  wire        is_legal   = is_noop || is_bus_op;
  wire        launch     = cmd_take && is_bus_op;

  // ------------------------------------------------------------------
  // quarter-phase timing and step boundaries
  // ------------------------------------------------------------------
  wire        phase_last = tick && (quarter_ff == Q_DATA_B);
  wire        byte_step  = (state_ff == ST_XFER);
  wire        last_bit   = (bit_idx_ff == ACK_SLOT);
  wire        seq_done   = phase_last && (!byte_step || last_bit);

  // divider runs while a sequence is active or the idle clock is enabled
  scl_tick_gen #(
    .DIV       (QUARTER_DIV)
  ) u_tick (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (!idle || clk_run_ff),
    .i_restart (launch),
    .o_tick    (tick)
  );

  // ------------------------------------------------------------------
  // line levels for the current step
  // ------------------------------------------------------------------
  // start: data rises in the low phase, falls while clock high
  // stop:  data falls in the low phase, rises while clock high
  // bits:  data set in the low phase and held through the high phase
  wire        tx_bit     = last_bit ? 1'b1 : shift_ff[7];
  wire        rx_bit     = last_bit ? 1'b0 : 1'b1;
  wire        bit_level  = receive_ff ? rx_bit : tx_bit;
  wire        level_a    = (state_ff == ST_START) ? 1'b1 :
                           (state_ff == ST_STOP)  ? 1'b0 : bit_level;
  wire        level_b    = (state_ff == ST_START) ? 1'b0 :
                           (state_ff == ST_STOP)  ? 1'b1 : bit_level;

  // next sequence state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (launch) begin
          // RL10 stop issue
          // RL11 start issue
          nxt_state = is_start ? ST_START :
                      is_stop  ? ST_STOP  : ST_XFER;
        end
      end
      ST_START, ST_STOP, ST_XFER: begin
        if (seq_done) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // sequence registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // quarter counter and bit index
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quarter_ff <= Q_CLK_LOW;
      bit_idx_ff <= 4'h0;
      receive_ff <= 1'b0;
    end else if (launch) begin
      quarter_ff <= Q_CLK_LOW;
      bit_idx_ff <= 4'h0;
      receive_ff <= is_rx;
    end else if (tick) begin
      quarter_ff <= quarter_ff + 2'h1;
      if (phase_last && byte_step && !last_bit) begin
        bit_idx_ff <= bit_idx_ff + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // serial clock and data drive
  // ------------------------------------------------------------------
  // RL14 no stretching: the clock line is never read back
  // RL8 clock held high when stopped
  // RL9 idle toggle until no-op
  // RL17 byte data moves only with clock low; start and stop move it while clock high
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else if (!idle && tick) begin
      unique case (quarter_ff)
        Q_CLK_LOW:  scl_ff <= 1'b0;
        Q_DATA_A:   sda_ff <= level_a;
        Q_CLK_HIGH: scl_ff <= 1'b1;
        Q_DATA_B:   sda_ff <= level_b;
      endcase
    end else if (idle && clk_run_ff && tick && quarter_ff[0]) begin
      scl_ff <= ~scl_ff;
    end else if (idle && !clk_run_ff) begin
      scl_ff <= 1'b1;
    end
  end

  // idle clock enable: any bus command starts it, no-op stops it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_run_ff <= 1'b0;
    end else if (cmd_take && is_noop) begin
      clk_run_ff <= 1'b0;
    end else if (launch) begin
      clk_run_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // shift register and data byte
  // ------------------------------------------------------------------
  // one register serves both directions; msb leaves first, lsb enters last
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_ff <= BYTE_RESET;
    end else if (launch) begin
      // RL2 load byte to send
      shift_ff <= serial_byte_ff;
    end else if (phase_last && byte_step && !last_bit) begin
      // RL17 msb first
      shift_ff <= {shift_ff[6:0], sda_in};
    end
  end

  // data register: processor writes when idle, receive result on completion
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      serial_byte_ff <= BYTE_RESET;
    end else if (seq_done && byte_step && receive_ff) begin
      // RL7 present received byte
      serial_byte_ff <= shift_ff;
    end else if (byte_wr && idle) begin
      // RL1 byte staged before command
      serial_byte_ff <= i_sfr_wdata;
    end
  end

  // ------------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_ff.error    <= 1'b0;
      status_ff.busy     <= 1'b0;
      status_ff.rx_ack_n <= ACK_N_RESET;
      status_ff.tx_ack_n <= ACK_N_RESET;
    end else begin
      // RL12 illegal command flag
      if (cmd_take) begin
        status_ff.error <= !is_legal;
      end
      // RL3 busy while sequence runs
      if (launch) begin
        status_ff.busy <= 1'b1;
      end else if (seq_done) begin
        status_ff.busy <= 1'b0;
      end
      // RL5 eeprom acknowledge sampled
      if (launch && is_tx) begin
        status_ff.rx_ack_n <= ACK_N_RESET;
      end else if (seq_done && byte_step && !receive_ff) begin
        status_ff.rx_ack_n <= sda_in;
      end
      // RL6 own acknowledge driven
      if (launch && is_rx) begin
        status_ff.tx_ack_n <= ACK_N_RESET;
      end else if (seq_done && byte_step && receive_ff) begin
        status_ff.tx_ack_n <= 1'b0;
      end
    end
  end

  // RL4 done pulse on busy fall
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= status_ff.busy && seq_done;
    end
  end

  // ------------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------------
  // RL13 command field reads back as zero
  wire [7:0] status_word = {status_ff, STAT_LOW_PAD};
  wire [7:0] rdata_sel   = (i_sfr_addr == SERIAL_CMD_ADDR)  ? status_word :
                           (i_sfr_addr == SERIAL_BYTE_ADDR) ? serial_byte_ff :
                           RDATA_RESET;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= RDATA_RESET;
    end else begin
      rdata_ff <= rdata_sel;
    end
  end

  // ------------------------------------------------------------------
  // shared pin routing
  // ------------------------------------------------------------------
  // open drain: a high level is released, a low level is driven
  // RL15 routed only when selected
  // RL16 gpio path kept intact for direct control
  wire pin_sel = i_eeprom_pin_select;
  pin_drive_s clk_pin_sel;
  pin_drive_s data_pin_sel;
  assign clk_pin_sel  = pin_sel ? '{out: 1'b0, oe: ~scl_ff} : i_gpio_clock;
  assign data_pin_sel = pin_sel ? '{out: 1'b0, oe: ~sda_ff} : i_gpio_data;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_pin_ff  <= '{out: 1'b0, oe: 1'b0};
      data_pin_ff <= '{out: 1'b0, oe: 1'b0};
    end else begin
      clk_pin_ff  <= clk_pin_sel;
      data_pin_ff <= data_pin_sel;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_sfr_rdata            = rdata_ff;
  assign o_eeprom_done_irq      = irq_ff;
  assign o_shared_pin_clock_out = clk_pin_ff.out;
  assign o_shared_pin_clock_oe  = clk_pin_ff.oe;
  assign o_shared_pin_data_out  = data_pin_ff.out;
  assign o_shared_pin_data_oe   = data_pin_ff.oe;
  assign o_gpio_clock_in        = scl_sync_ff[1];
  assign o_gpio_data_in         = sda_sync_ff[1];

endmodule : eeprom_i2c_master

// [dv/eeprom_i2c_monitor.sv]
// Purpose: port checker for the serial eeprom master
// Assumes: one clock, async active-high reset
// Notes:   busy is rebuilt here from accepted commands
`timescale 1ns/10ps
module eeprom_i2c_monitor
  import eeprom_i2c_pkg::*;
#(
  parameter int QUARTER_DIV = 4
) (
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  input wire logic [7:0]                 i_sfr_addr,
  input wire logic                       i_sfr_wr,
  input wire logic [7:0]                 i_sfr_wdata,
  input wire logic [7:0]                 o_sfr_rdata,
  input wire logic                       i_eeprom_pin_select,
  input wire eeprom_i2c_pkg::pin_drive_s i_gpio_clock,
  input wire eeprom_i2c_pkg::pin_drive_s i_gpio_data,
  input wire logic                       o_shared_pin_clock_out,
  input wire logic                       o_shared_pin_clock_oe,
  input wire logic                       o_shared_pin_data_out,
  input wire logic                       o_shared_pin_data_oe,
  input wire logic                       o_eeprom_done_irq
);
  localparam int NOOP_MAX = 4 * QUARTER_DIV + 8;
  localparam int XFER_MIN = 36 * QUARTER_DIV - 1;
  localparam int COND_MIN = 4 * QUARTER_DIV - 1;
  logic       busy_ff;
  logic [3:0] kind_ff;
  int         cnt_ff;
  // command decode; writes while busy are dropped
  wire logic cmd_wr  = i_sfr_wr && i_sfr_addr == SERIAL_CMD_ADDR && !busy_ff;
  wire logic bus_cmd = cmd_wr
                       && i_sfr_wdata[3:0] inside {CMD_TRANSMIT, CMD_STOP, CMD_RECEIVE, CMD_START};
  wire logic noop_wr = cmd_wr && i_sfr_wdata[3:0] == CMD_NOOP && i_eeprom_pin_select;
  wire logic is_xfer = kind_ff inside {CMD_TRANSMIT, CMD_RECEIVE};
  wire logic mapped  = i_sfr_addr inside {SERIAL_BYTE_ADDR, SERIAL_CMD_ADDR};

  // cycles since the last accepted bus command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_ff <= 1'b0;
      kind_ff <= 4'h0;
      cnt_ff  <= 0;
    end else if (bus_cmd) begin
      busy_ff <= 1'b1;
      kind_ff <= i_sfr_wdata[3:0];
      cnt_ff  <= 0;
    end else begin
      cnt_ff <= cnt_ff + 1;
      if (o_eeprom_done_irq) busy_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_irq_pulse; o_eeprom_done_irq |=> !o_eeprom_done_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("done pulse wider than one cycle");
  property p_irq_cause; o_eeprom_done_irq |-> busy_ff; endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("done pulse without a bus command");
  property p_xfer_len;
    o_eeprom_done_irq && is_xfer |-> cnt_ff inside {[XFER_MIN:XFER_MIN + QUARTER_DIV + 1]};
  endproperty
  a_xfer_len: assert property (p_xfer_len)
    else $error("byte transfer length is not nine bits");
  property p_cond_len;
    o_eeprom_done_irq && !is_xfer |-> cnt_ff inside {[COND_MIN:COND_MIN + QUARTER_DIV + 1]};
  endproperty
  a_cond_len: assert property (p_cond_len)
    else $error("start or stop length wrong");
  property p_noop_stop; noop_wr |-> ##[1:NOOP_MAX] !o_shared_pin_clock_oe; endproperty
  a_noop_stop: assert property (p_noop_stop)
    else $error("clock not released after no-op");
  property p_cmd_pad; i_sfr_addr == SERIAL_CMD_ADDR |=> o_sfr_rdata[3:0] == STAT_LOW_PAD; endproperty
  a_cmd_pad: assert property (p_cmd_pad)
    else $error("command field readable");
  property p_unmapped; !mapped |=> o_sfr_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address reads nonzero");
  property p_mux;
    !i_eeprom_pin_select && !$past(i_eeprom_pin_select) && !$past(i_sys_rst)
      |-> o_shared_pin_clock_oe == $past(i_gpio_clock.oe)
          && o_shared_pin_data_out == $past(i_gpio_data.out);
  endproperty
  a_mux: assert property (p_mux)
    else $error("gpio drive not passed to pins");
  property p_open_drain;
    i_eeprom_pin_select && $past(i_eeprom_pin_select) && !$past(i_sys_rst)
      |-> !o_shared_pin_clock_out && !o_shared_pin_data_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high while selected");

  c_xfer: cover property (o_eeprom_done_irq && is_xfer);
  c_noop: cover property (noop_wr);
  c_ill:  cover property (cmd_wr && !bus_cmd && i_sfr_wdata[3:0] != CMD_NOOP);
endmodule : eeprom_i2c_monitor

bind eeprom_i2c_master eeprom_i2c_monitor #(.QUARTER_DIV(QUARTER_DIV)) u_mon (.*);

// [dv/eeprom_model.sv]
// Purpose: behavioural serial eeprom on two pulled-up lines
// Assumes: bench gives the role of each byte and a restart pulse
// Notes:   no address decoding; counts start and stop conditions
`timescale 1ns/10ps
module eeprom_model (
  input  wire logic       i_clk,
  input  wire logic       i_restart,
  input  wire logic       i_send,
  input  wire logic       i_ack_en,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_low,
  output logic [7:0]      o_rx_byte,
  output int              o_starts,
  output int              o_stops
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int   bit_n = 9;
  initial begin
    o_sda_low = 1'b0;
    o_starts  = 0;
    o_stops   = 0;
  end
  // msb first, data moves only while clock low
  always @(posedge i_clk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (i_scl && scl_q && sda_q && !i_sda) o_starts <= o_starts + 1;
    if (i_scl && scl_q && !sda_q && i_sda) o_stops <= o_stops + 1;
    if (i_restart) bit_n <= 0;
    else if (i_scl && !scl_q && bit_n < 9) begin
      bit_n <= bit_n + 1;
      if (bit_n < 8) o_rx_byte <= {o_rx_byte[6:0], i_sda};
    end
    if (!i_scl) o_sda_low <= (bit_n < 8) ? (i_send && !i_tx_byte[7 - bit_n])
                                         : (bit_n == 8 && !i_send && i_ack_en);
  end
endmodule : eeprom_model

// [dv/tb_eeprom_i2c_master.sv]
// Purpose: self-checking bench for the serial eeprom master
// Assumes: model eeprom on pulled-up open drain lines
// Notes:   short quarter divider keeps the run brief
`timescale 1ns/10ps
module tb_eeprom_i2c_master;
  import eeprom_i2c_pkg::*;
  localparam int Q = 4;
  logic       i_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       sel = 1'b0;
  logic       restart = 1'b0;
  logic       send = 1'b0;
  logic       ack_en = 1'b0;
  logic [7:0] txb = 8'h00;
  pin_drive_s gclk = '0;
  pin_drive_s gdat = '0;
  logic [7:0] rdata, rxb, v, b;
  logic       gclk_in, gdat_in, clk_out, clk_oe, dat_out, dat_oe, irq, sda_low;
  int         starts, stops, n, seed, errors = 0, n_tests = 0, cycles = 0;
  // pulled-up open drain lines
  wire logic scl_w = !(clk_oe && !clk_out);
  wire logic sda_w = !(dat_oe && !dat_out) && !sda_low;

  always #12.5 i_clk = ~i_clk;

  eeprom_i2c_master #(.QUARTER_DIV(Q)) DUT (
    .i_clk(i_clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_eeprom_pin_select(sel),
    .i_gpio_clock(gclk), .i_gpio_data(gdat), .o_gpio_clock_in(gclk_in),
    .o_gpio_data_in(gdat_in), .i_shared_pin_clock_in(scl_w),
    .o_shared_pin_clock_out(clk_out), .o_shared_pin_clock_oe(clk_oe),
    .i_shared_pin_data_in(sda_w), .o_shared_pin_data_out(dat_out),
    .o_shared_pin_data_oe(dat_oe), .o_eeprom_done_irq(irq));

  eeprom_model u_eeprom (
    .i_clk(i_clk), .i_restart(restart), .i_send(send), .i_ack_en(ack_en),
    .i_tx_byte(txb), .i_scl(scl_w), .i_sda(sda_w), .o_sda_low(sda_low),
    .o_rx_byte(rxb), .o_starts(starts), .o_stops(stops));

  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // expected line level of an open drain drive on a pulled-up pin
  function automatic logic pin_level(input pin_drive_s d);
    return !(d.oe && !d.out);
  endfunction : pin_level

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    restart = r;
    @(negedge i_clk);
    wr = 1'b0;
    restart = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    @(negedge i_clk);
    d = rdata;
  endtask : rd_reg

  // one bus command, waits for the done pulse under a bound
  task automatic bus_cmd(input logic [3:0] c, input logic s, input logic k, input logic [7:0] t);
    logic [7:0] st;
    logic       got;
    send = s;
    ack_en = k;
    txb = t;
    wr_reg(SERIAL_CMD_ADDR, {4'h0, c}, 1'b1);
    rd_reg(SERIAL_CMD_ADDR, st);
    check("busy during op", st[STAT_BUSY_BIT], 1'b1);
    got = 1'b0;
    // next command only after busy falls
    for (int i = 0; i < 40 * Q + 40 && !got; i++) begin
      @(negedge i_clk);
      got = (irq === 1'b1);
    end
    check("done pulse", got, 1'b1);
    rd_reg(SERIAL_CMD_ADDR, st);
    check("busy after op", st[STAT_BUSY_BIT], 1'b0);
  endtask : bus_cmd

  initial begin
    seed = 32'h26d3;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    rst = 1'b0;
    rd_reg(SERIAL_CMD_ADDR, v);
    check("status reset", v, 8'h30);
    check("rx ack reset", v[STAT_RXACK_BIT], 1'b1);
    check("tx ack reset", v[STAT_TXACK_BIT], 1'b1);
    rd_reg(SERIAL_BYTE_ADDR, v);
    check("data reset", v, BYTE_RESET);
    rd_reg(8'h55, v);
    check("unmapped read", v, 8'h00);
    sel = 1'b1;
    bus_cmd(CMD_START, 1'b0, 1'b0, 8'h00);
    check("start count", starts, 1);
    // second byte is left unacknowledged
    for (int i = 0; i < 3; i++) begin
      b = $random(seed);
      wr_reg(SERIAL_BYTE_ADDR, b, 1'b0);
      bus_cmd(CMD_TRANSMIT, 1'b0, i != 1, 8'h00);
      check("byte sent", rxb, b);
      rd_reg(SERIAL_CMD_ADDR, v);
      check("eeprom ack bit", v[STAT_RXACK_BIT], i == 1);
    end
    b = $random(seed);
    bus_cmd(CMD_RECEIVE, 1'b1, 1'b0, b);
    rd_reg(SERIAL_BYTE_ADDR, v);
    check("byte received", v, b);
    rd_reg(SERIAL_CMD_ADDR, v);
    check("master ack bit", v[STAT_TXACK_BIT], 1'b0);
    bus_cmd(CMD_STOP, 1'b0, 1'b0, 8'h00);
    check("stop count", stops, 1);
    check("no stray start", starts, 1);
    // without a no-op the serial clock must keep running
    n = 0;
    repeat (8 * Q) begin
      @(negedge i_clk);
      if (scl_w === 1'b0) n++;
    end
    check("idle clock toggles", n != 0, 1'b1);
    wr_reg(SERIAL_CMD_ADDR, {4'h0, CMD_NOOP}, 1'b0);
    repeat (6 * Q) @(negedge i_clk);
    n = 0;
    repeat (200) begin
      @(negedge i_clk);
      if (scl_w !== 1'b1) n++;
    end
    check("clock low while stopped", n, 0);
    // every undefined code, random upper bits
    for (int c = 1; c < 16; c++) begin
      if (c inside {3, 5, 6, 9}) continue;
      b = $random(seed);
      wr_reg(SERIAL_CMD_ADDR, {b[7:4], c[3:0]}, 1'b0);
      rd_reg(SERIAL_CMD_ADDR, v);
      check("error bit", v[STAT_ERROR_BIT], 1'b1);
      check("no bus activity", v[STAT_BUSY_BIT], 1'b0);
      check("command field", v[3:0], 4'h0);
    end
    wr_reg(SERIAL_CMD_ADDR, {4'h0, CMD_NOOP}, 1'b0);
    rd_reg(SERIAL_CMD_ADDR, v);
    check("error cleared", v[STAT_ERROR_BIT], 1'b0);
    // direct pin drive only once the eeprom frame is closed
    sel = 1'b0;
    repeat (6) begin
      @(negedge i_clk);
      b = $random(seed);
      gclk = b[1:0];
      gdat = b[3:2];
      repeat (5) @(negedge i_clk);
      check("gpio clock drive", {clk_out, clk_oe}, b[1:0]);
      check("gpio data drive", {dat_out, dat_oe}, b[3:2]);
      check("gpio clock level", gclk_in, pin_level(b[1:0]));
      check("gpio data level", gdat_in, pin_level(b[3:2]));
    end
    give_verdict();
  end
endmodule : tb_eeprom_i2c_master
